// ---- rtl/pmscr_regs.svh ----
`ifndef PMSCR_REGS_SVH
`define PMSCR_REGS_SVH
// command codes
`define PMSCR_CMD_CLEAR_FAULTS  8'h03
`define PMSCR_CMD_CML_STATUS    8'h7a
`define PMSCR_CMD_TEMP_STATUS   8'h7d
`define PMSCR_CMD_INPUT_VOLTAGE_READING      8'h88
`define PMSCR_CMD_READ_VOUT     8'h8b
`define PMSCR_CMD_OUTPUT_CURRENT_READING     8'h8c
`define PMSCR_CMD_READ_TEMP     8'h8d
`define PMSCR_CMD_MODULE_TYPE   8'hd0
`define PMSCR_CMD_VOUT_GAIN     8'hd1
`define PMSCR_CMD_VOUT_OFFSET   8'hd2
`define PMSCR_CMD_VIN_GAIN      8'hd3
`define PMSCR_CMD_VIN_OFFSET    8'hd4
`define PMSCR_CMD_IOUT_GAIN     8'hd6
`define PMSCR_CMD_IOUT_OFFSET   8'hd7
`define PMSCR_CMD_FW_REV        8'hdb
`define PMSCR_CMD_PIN_CFG       8'he0
// status bit positions
`define PMSCR_TEMP_OVERTEMP_FAULT_FLAG     7
`define PMSCR_TEMP_OVERTEMP_WARNING_FLAG      6
`define PMSCR_CML_INV_CMD       7
`define PMSCR_CML_INV_DATA      6
`define PMSCR_CML_PEC_FAIL      5
// module type word fields
`define PMSCR_MT_WPE            1
`define PMSCR_MT_NAME_HI        7
`define PMSCR_MT_NAME_LO        2
// module designation code, arbitrary value
`define PMSCR_MT_NAME_RST       6'h2a
`define PMSCR_MT_WPE_RST        1'b1
// pin/alert configuration fields
`define PMSCR_CFG_ARA           4
`define PMSCR_CFG_PIN_HI        3
`define PMSCR_CFG_RST           8'h00
`define PMSCR_PIN_ONOFF_PG      4'h0
`define PMSCR_PIN_TRIM_PG       4'h1
`define PMSCR_PIN_TRIM_ONOFF    4'h2
// calibration limits and resets
`define PMSCR_GAIN_MIN          16'h1999
`define PMSCR_GAIN_MAX          16'h2666
`define PMSCR_GAIN_RST          16'h2000
`define PMSCR_OFFSET_RST        16'h0000
`define PMSCR_EXP_VOUT          5'h14
`define PMSCR_EXP_VIN           5'h1d
`define PMSCR_EXP_IOUT          5'h1c
`endif

// ---- rtl/pmscr_pkg.sv ----
package pmscr_pkg;
  // one transaction handed over by the link front end
  typedef struct packed {
    logic        write;   // 1 write, 0 read
    logic        pec_bad; // packet error check failed
    logic [7:0]  cmd;     // command code
    logic [15:0] data;    // write data, low byte first on the wire
  } pmscr_req_t;

  // telemetry codes from the conversion logic
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } pmscr_telem_t;

  // readback calibration words
  typedef struct packed {
    logic [15:0] vout_gain;
    logic [15:0] vout_off;
    logic [15:0] vin_gain;
    logic [15:0] vin_off;
    logic [15:0] iout_gain;
    logic [15:0] iout_off;
  } pmscr_cal_t;

  typedef enum logic {
    PMSCR_LS_IDLE = 1'b0,
    PMSCR_LS_WAIT = 1'b1
  } pmscr_lstate_t;
endpackage

// ---- rtl/pmscr_sync.sv ----
`timescale 1ns/10ps
module pmscr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // destination clock
  input  wire logic         rst_n,  // async reset
  input  wire logic [W-1:0] d,      // asynchronous level
  output logic      [W-1:0] q       // synchronised level
);
  logic [W-1:0] meta_q;
  // two flip-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // pmscr_sync

// ---- rtl/pmscr_top.sv ----
`timescale 1ns/10ps
`include "pmscr_regs.svh"
//
// Contract
// - temp status: fault bit7, warning bit6
// - comm status: bad cmd, bad data, PEC
// - module word bit1 is write protect
// - module word bits 7:2 hold designation
// - gain words accept only in-range values
// - offset words need their fixed exponent
// - calibration words retained, locked by protect; the code reloads their reset values on resetn
// - firmware revision byte is read-only
// - alert bit selects alert-address-only answering
// - pin code selects multipurpose pin functions
// - load-share units allow only code 0000
module pmscr_top (
  input  wire logic                ref_clk,         // system clock
  input  wire logic                resetn,          // async reset
  input  wire logic                link_clk,        // link clock
  input  wire logic                link_req_valid,  // request pulse, link domain
  input  wire pmscr_pkg::pmscr_req_t link_req,     // request contents
  output logic                     link_busy,       // request outstanding
  output logic                     link_resp_valid, // answer pulse, link domain
  output logic [15:0]              link_resp_data,  // read data
  input  wire logic                overtemp_fault_flag_evt,    // over-temperature fault
  input  wire logic                overtemp_warning_flag_evt,     // over-temperature warning
  input  wire pmscr_pkg::pmscr_telem_t telem,      // telemetry codes
  input  wire logic [7:0]          fw_rev,          // firmware revision
  input  wire logic                load_share_opt,  // load-share build strap
  input  wire logic                smbalert,        // alert line asserted
  output pmscr_pkg::pmscr_cal_t    cal,             // calibration words
  output logic                     write_protect,   // protect enable
  output logic [3:0]               pin_func,        // multipurpose pin code
  output logic                     ara_only         // answer alert address only
);
  import pmscr_pkg::*;

  // ---------------- link domain ----------------
  pmscr_lstate_t ls_q, ls_d;
  pmscr_req_t    req_q, req_d;
  logic          req_tgl_q, req_tgl_d;
  logic          ack_seen_q, ack_seen_d;
  logic          busy_d, rvalid_d;
  logic [15:0]   rdata_d;
  logic          ack_ls;
  logic          ack_tgl_q, ack_tgl_d;
  logic [15:0]   resp_q, resp_d;

  pmscr_sync #(.W(1)) u_ack_sync (
    .clk   (link_clk),
    .rst_n (resetn),
    .d     (ack_tgl_q),
    .q     (ack_ls)
  );

  // capture request, toggle to core, wait for answer toggle
  always_comb begin
    ls_d       = ls_q;
    req_d      = req_q;
    req_tgl_d  = req_tgl_q;
    ack_seen_d = ack_seen_q;
    busy_d     = link_busy;
    rvalid_d   = 1'b0;
    rdata_d    = link_resp_data;
    case (ls_q)
      PMSCR_LS_IDLE: begin
        if (link_req_valid) begin
          req_d     = link_req;
          req_tgl_d = ~req_tgl_q;
          busy_d    = 1'b1;
          ls_d      = PMSCR_LS_WAIT;
        end
      end
      PMSCR_LS_WAIT: begin
        if (ack_ls != ack_seen_q) begin
          ack_seen_d = ack_ls;
          rdata_d    = resp_q; // held stable by the core until next request
          rvalid_d   = 1'b1;
          busy_d     = 1'b0;
          ls_d       = PMSCR_LS_IDLE;
        end
      end
      default: ls_d = PMSCR_LS_IDLE;
    endcase
  end

  // link domain registers
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      ls_q            <= PMSCR_LS_IDLE;
      req_q           <= '0;
      req_tgl_q       <= 1'b0;
      ack_seen_q      <= 1'b0;
      link_busy       <= 1'b0;
      link_resp_valid <= 1'b0;
      link_resp_data  <= 16'h0000;
    end else begin
      ls_q            <= ls_d;
      req_q           <= req_d;
      req_tgl_q       <= req_tgl_d;
      ack_seen_q      <= ack_seen_d;
      link_busy       <= busy_d;
      link_resp_valid <= rvalid_d;
      link_resp_data  <= rdata_d;
    end
  end

  // ---------------- core domain ----------------
  logic       req_s;
  logic [1:0] pins_s;
  logic       seen_q, seen_d;
  logic       new_req;
  logic [7:0] temp_q, temp_d;
  logic [7:0] cml_q, cml_d;
  logic [5:0] name_q, name_d;
  logic       wpe_q, wpe_d;
  logic [4:0] cfg_q, cfg_d;
  logic       ara_d;
  pmscr_cal_t cal_d;

  pmscr_sync #(.W(1)) u_req_sync (
    .clk   (ref_clk),
    .rst_n (resetn),
    .d     (req_tgl_q),
    .q     (req_s)
  );

  // pins: load-share strap and alert line
  pmscr_sync #(.W(2)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (resetn),
    .d     ({load_share_opt, smbalert}),
    .q     (pins_s)
  );

  assign new_req = (req_s != seen_q);

  // command decode, status latching and calibration checks
  always_comb begin
    logic [15:0] rd;
    logic        bad_cmd;
    logic        bad_data;
    logic        pec;
    logic        wr;
    logic [15:0] wd;
    rd       = 16'h0000;
    bad_cmd  = 1'b0;
    bad_data = 1'b0;
    pec      = 1'b0;
    wr       = req_q.write;
    wd       = req_q.data;
    seen_d   = req_s;
    temp_d   = temp_q;
    cml_d    = cml_q;
    name_d   = name_q;
    wpe_d    = wpe_q;
    cfg_d    = cfg_q;
    cal_d    = cal;
    resp_d   = resp_q;
    ack_tgl_d = ack_tgl_q;
    if (new_req) begin
      ack_tgl_d = ~ack_tgl_q;
      if (req_q.pec_bad) begin
        pec = 1'b1;
      end else begin
        case (req_q.cmd)
          `PMSCR_CMD_CLEAR_FAULTS: begin
            if (wr) begin
              temp_d = 8'h00;
              cml_d  = 8'h00;
            end else bad_cmd = 1'b1;
          end
          `PMSCR_CMD_CML_STATUS: begin
            if (wr) cml_d = cml_q & ~wd[7:0];
            else rd = {8'h00, cml_q};
          end
          `PMSCR_CMD_TEMP_STATUS: begin
            if (wr) temp_d = temp_q & ~wd[7:0];
            else rd = {8'h00, temp_q};
          end
          `PMSCR_CMD_INPUT_VOLTAGE_READING:  if (wr) bad_data = 1'b1; else rd = telem.vin;
          `PMSCR_CMD_READ_VOUT: if (wr) bad_data = 1'b1; else rd = telem.vout;
          `PMSCR_CMD_OUTPUT_CURRENT_READING: if (wr) bad_data = 1'b1; else rd = telem.iout;
          `PMSCR_CMD_READ_TEMP: if (wr) bad_data = 1'b1; else rd = telem.temp;
          `PMSCR_CMD_FW_REV: begin
            if (wr) bad_data = 1'b1;
            else rd = {8'h00, fw_rev};
          end
          `PMSCR_CMD_MODULE_TYPE: begin
            if (wr) begin
              name_d = wd[`PMSCR_MT_NAME_HI:`PMSCR_MT_NAME_LO];
              wpe_d  = wd[`PMSCR_MT_WPE];
            end else rd = {8'h00, name_q, wpe_q, 1'b0};
          end
          `PMSCR_CMD_VOUT_GAIN, `PMSCR_CMD_VIN_GAIN, `PMSCR_CMD_IOUT_GAIN: begin
            if (!wr) begin
              case (req_q.cmd)
                `PMSCR_CMD_VOUT_GAIN: rd = cal.vout_gain;
                `PMSCR_CMD_VIN_GAIN:  rd = cal.vin_gain;
                default:              rd = cal.iout_gain;
              endcase
            end else if (wpe_q || wd < `PMSCR_GAIN_MIN || wd > `PMSCR_GAIN_MAX) begin
              bad_data = 1'b1;
            end else begin
              case (req_q.cmd)
                `PMSCR_CMD_VOUT_GAIN: cal_d.vout_gain = wd;
                `PMSCR_CMD_VIN_GAIN:  cal_d.vin_gain  = wd;
                default:              cal_d.iout_gain = wd;
              endcase
            end
          end
          `PMSCR_CMD_VOUT_OFFSET: begin
            if (!wr) rd = cal.vout_off;
            else if (wpe_q || wd[15:11] != `PMSCR_EXP_VOUT) bad_data = 1'b1;
            else cal_d.vout_off = wd;
          end
          `PMSCR_CMD_VIN_OFFSET: begin
            if (!wr) rd = cal.vin_off;
            else if (wpe_q || wd[15:11] != `PMSCR_EXP_VIN) bad_data = 1'b1;
            else cal_d.vin_off = wd;
          end
          `PMSCR_CMD_IOUT_OFFSET: begin
            if (!wr) rd = cal.iout_off;
            else if (wpe_q || wd[15:11] != `PMSCR_EXP_IOUT) bad_data = 1'b1;
            else cal_d.iout_off = wd;
          end
          `PMSCR_CMD_PIN_CFG: begin
            if (!wr) begin
              rd = {11'h000, cfg_q};
            end else if (wd[`PMSCR_CFG_PIN_HI:0] > `PMSCR_PIN_TRIM_ONOFF ||
                         (pins_s[1] && wd[`PMSCR_CFG_PIN_HI:0] != `PMSCR_PIN_ONOFF_PG)) begin
              bad_data = 1'b1;
            end else begin
              cfg_d = wd[`PMSCR_CFG_ARA:0];
            end
          end
          default: bad_cmd = 1'b1;
        endcase
      end
      resp_d = rd;
    end
    // events set after clears so a coincident event is kept
    if (overtemp_fault_flag_evt) temp_d[`PMSCR_TEMP_OVERTEMP_FAULT_FLAG] = 1'b1;
    if (overtemp_warning_flag_evt) temp_d[`PMSCR_TEMP_OVERTEMP_WARNING_FLAG] = 1'b1;
    if (bad_cmd) cml_d[`PMSCR_CML_INV_CMD] = 1'b1;
    if (bad_data) cml_d[`PMSCR_CML_INV_DATA] = 1'b1;
    if (pec) cml_d[`PMSCR_CML_PEC_FAIL] = 1'b1;
    temp_d[5:0] = 6'h00;
    cml_d[4:0]  = 5'h00;
    ara_d = cfg_q[`PMSCR_CFG_ARA] & pins_s[0];
  end

  // core registers; calibration words reload their gain and offset reset values on resetn
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen_q        <= 1'b0;
      ack_tgl_q     <= 1'b0;
      resp_q        <= 16'h0000;
      temp_q        <= 8'h00;
      cml_q         <= 8'h00;
      name_q        <= `PMSCR_MT_NAME_RST;
      wpe_q         <= `PMSCR_MT_WPE_RST;
      cfg_q         <= 5'(`PMSCR_CFG_RST);
      cal.vout_gain <= `PMSCR_GAIN_RST;
      cal.vout_off  <= `PMSCR_OFFSET_RST;
      cal.vin_gain  <= `PMSCR_GAIN_RST;
      cal.vin_off   <= `PMSCR_OFFSET_RST;
      cal.iout_gain <= `PMSCR_GAIN_RST;
      cal.iout_off  <= `PMSCR_OFFSET_RST;
      write_protect <= `PMSCR_MT_WPE_RST;
      pin_func      <= 4'h0;
      ara_only      <= 1'b0;
    end else begin
      seen_q        <= seen_d;
      ack_tgl_q     <= ack_tgl_d;
      resp_q        <= resp_d;
      temp_q        <= temp_d;
      cml_q         <= cml_d;
      name_q        <= name_d;
      wpe_q         <= wpe_d;
      cfg_q         <= cfg_d;
      cal           <= cal_d;
      write_protect <= wpe_d;
      pin_func      <= cfg_d[`PMSCR_CFG_PIN_HI:0];
      ara_only      <= ara_d;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_overtemp_fault_flag_latch: assert property (overtemp_fault_flag_evt |=> temp_q[7] [*2])
    else $error("fault bit not latched");
  a_overtemp_warning_flag_latch: assert property (overtemp_warning_flag_evt |=> temp_q[6])
    else $error("warning bit not latched");
  a_unsup_zero: assert property (temp_q[5:0] == 6'h00 && cml_q[4:0] == 5'h00)
    else $error("unsupported status bit set");
  a_sticky_hold: assert property (temp_q[7] && !new_req |=> temp_q[7])
    else $error("status bit dropped without clear");
  a_bad_cmd_flag: assert property (new_req && !req_q.pec_bad &&
                                   !(req_q.cmd inside {8'h03, 8'h7a, 8'h7d, 8'h88, [8'h8b:8'h8d], [8'hd0:8'hd4],
                                                       8'hd6, 8'hd7, 8'hdb, 8'he0}) |=> cml_q[7])
    else $error("invalid command not flagged");
  a_pec_flag: assert property (new_req && req_q.pec_bad |=> cml_q[5] && $stable(cal))
    else $error("pec failure not flagged");
  a_wp_lock: assert property (new_req && wpe_q && req_q.write && !req_q.pec_bad &&
                              req_q.cmd inside {[8'hd1:8'hd4], 8'hd6, 8'hd7} |=> $stable(cal) && cml_q[6])
    else $error("protected calibration write taken");
  a_gain_range: assert property (cal.vout_gain >= 16'h1999 && cal.vout_gain <= 16'h2666 &&
                                 cal.vin_gain >= 16'h1999 && cal.vin_gain <= 16'h2666 &&
                                 cal.iout_gain >= 16'h1999 && cal.iout_gain <= 16'h2666)
    else $error("gain word out of range");
  a_offset_exp: assert property ($changed(cal.vin_off) |-> cal.vin_off[15:11] == 5'h1d)
    else $error("offset exponent wrong");
  a_pin_code: assert property (pin_func <= 4'h2 and (pins_s[1] && $changed(pin_func) |-> pin_func == 4'h0))
    else $error("illegal pin code held");
  a_ara_follow: assert property (ara_only == $past(cfg_q[4] & pins_s[0], 1))
    else $error("alert address mode wrong");
  a_wp_out: assert property (write_protect == wpe_q)
    else $error("protect output mismatch");
  a_ack_toggle: assert property (new_req |=> ack_tgl_q != $past(ack_tgl_q) ##1 !new_req)
    else $error("request not answered once");
endmodule // pmscr_top

// ---- dv/pmscr_host_model.sv ----
`timescale 1ns/10ps
module pmscr_host_model (
  input  wire logic             link_clk,        // link clock
  input  wire logic             link_resp_valid, // answer pulse
  input  wire logic [15:0]      link_resp_data,  // answer data
  output pmscr_pkg::pmscr_req_t link_req,        // request contents
  output logic                  link_req_valid   // request pulse
);
  import pmscr_pkg::*;

  // idle link at time zero
  initial begin
    link_req_valid = 1'b0;
    link_req       = '0;
  end

  // one request held over its sampling edge, then a bounded wait for the answer
  task automatic xfer(input logic w, input logic pb, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q, output bit ok);
    ok = 1'b0;
    q  = '0;
    @(posedge link_clk);
    #2;
    link_req       = {w, pb, c, d};
    link_req_valid = 1'b1;
    @(posedge link_clk);
    #2;
    link_req_valid = 1'b0;
    link_req       = ~link_req; // released contents do not keep the old value
    for (int n = 0; n < 30 && !ok; n++) begin
      @(posedge link_clk);
      if (link_resp_valid === 1'b1) begin
        ok = 1'b1;
        q  = link_resp_data;
      end
    end
  endtask
endmodule // pmscr_host_model

// ---- dv/power_module_status_cal_regs_tb.sv ----
`timescale 1ns/10ps
`include "pmscr_regs.svh"
module power_module_status_cal_regs_tb;
  import pmscr_pkg::*;
  logic         ref_clk        = 1'b0;
  logic         link_clk       = 1'b0;
  logic         resetn         = 1'b0;
  logic         overtemp_fault_flag_evt   = 1'b0;
  logic         overtemp_warning_flag_evt    = 1'b0;
  logic         load_share_opt = 1'b0;
  logic         smbalert       = 1'b0;
  logic [7:0]   fw_rev         = 8'h00;
  pmscr_telem_t telem          = '0;
  pmscr_req_t   link_req;
  logic         link_req_valid;
  logic         link_busy;
  logic         link_resp_valid;
  logic         write_protect;
  logic         ara_only;
  logic [15:0]  link_resp_data;
  logic [15:0]  rd;
  logic [15:0]  d;
  logic [3:0]   pin_func;
  pmscr_cal_t   cal;
  logic [15:0]  cm [6];
  logic [7:0]   cmds [6] = '{8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6, 8'hd7};
  logic [7:0]   tcmd [4] = '{8'h88, 8'h8b, 8'h8c, 8'h8d};
  logic [7:0]   cfg;
  logic [5:0]   nm;
  logic         ok;
  integer       seed       = 73;
  int           mismatches = 0;
  int           n_tests    = 0;

  // clocks, link clock unrelated in phase
  always #20 ref_clk = ~ref_clk;
  always #24 link_clk = ~link_clk;

  pmscr_top uut (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
    .link_req_valid(link_req_valid), .link_req(link_req), .link_busy(link_busy),
    .link_resp_valid(link_resp_valid), .link_resp_data(link_resp_data),
    .overtemp_fault_flag_evt(overtemp_fault_flag_evt), .overtemp_warning_flag_evt(overtemp_warning_flag_evt), .telem(telem), .fw_rev(fw_rev),
    .load_share_opt(load_share_opt), .smbalert(smbalert), .cal(cal),
    .write_protect(write_protect), .pin_func(pin_func), .ara_only(ara_only));

  pmscr_host_model host (.link_clk(link_clk), .link_resp_valid(link_resp_valid),
    .link_resp_data(link_resp_data), .link_req(link_req), .link_req_valid(link_req_valid));

  // verdict and end of run
  task close_out;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // one link transfer; a missing answer ends the run
  task automatic acc(input logic w, input logic pb, input logic [7:0] c, input logic [15:0] dd);
    bit got;
    host.xfer(w, pb, c, dd, rd, got);
    if (!got) begin
      mismatches++;
      $display("CHECK FAILED t=%0t no answer to command %h", $time, c);
      close_out();
    end
  endtask

  // read and clear the communication status byte
  task automatic stat(input logic [7:0] e);
    acc(1'b0, 1'b0, 8'h7a, 16'h0000);
    check(rd, {8'h00, e}, "comm status");
    acc(1'b1, 1'b0, 8'h7a, 16'h00ff);
  endtask

  task automatic tstat(input logic [7:0] e);
    acc(1'b0, 1'b0, 8'h7d, 16'h0000);
    check(rd, {8'h00, e}, "temp status");
  endtask

  task automatic rwait(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk_cal;
    for (int i = 0; i < 6; i++) check(cal[95-16*i -: 16], cm[i], "cal port");
  endtask

  function automatic logic [4:0] ex_of(input int i);
    return (i < 2) ? `PMSCR_EXP_VOUT : (i < 4) ? `PMSCR_EXP_VIN : `PMSCR_EXP_IOUT;
  endfunction

  // gains need the range, offsets their fixed exponent
  function automatic logic cal_ok(input int i, input logic [15:0] v);
    if (i % 2 == 0) return v >= `PMSCR_GAIN_MIN && v <= `PMSCR_GAIN_MAX;
    return v[15:11] == ex_of(i);
  endfunction

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    repeat (3) @(posedge link_clk);
    for (int i = 0; i < 6; i++) cm[i] = (i % 2) ? `PMSCR_OFFSET_RST : `PMSCR_GAIN_RST;
    chk_cal();
    check({15'h0000, write_protect}, 16'h0001, "wpe reset");
    check({12'h000, pin_func}, 16'h0000, "pin reset");
    check({15'h0000, ara_only}, 16'h0000, "ara reset");
    acc(1'b0, 1'b0, 8'hd0, 16'h0000);
    check(rd, {8'h00, `PMSCR_MT_NAME_RST, 2'b10}, "module word");
    acc(1'b1, 1'b0, 8'hd1, 16'h2100);
    stat(8'h40);
    // clear protection before calibration writes, reserved bit 0 written high
    nm = 6'($random(seed));
    acc(1'b1, 1'b0, 8'hd0, {8'h00, nm, 2'b01});
    check({15'h0000, write_protect}, 16'h0000, "wpe off");
    acc(1'b0, 1'b0, 8'hd0, 16'h0000);
    check(rd, {8'h00, nm, 2'b00}, "module word");
    // corner and random values for every calibration word
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 6; k++) begin
        case (k)
          0: d = (i % 2) ? {ex_of(i), 11'h000} : 16'h1998;
          1: d = (i % 2) ? {ex_of(i), 11'h7ff} : 16'h1999;
          2: d = (i % 2) ? {ex_of(i) ^ 5'h01, 11'h123} : 16'h2666;
          3: d = (i % 2) ? 16'hffff : 16'h2667;
          default: d = 16'($random(seed));
        endcase
        if (k == 4 && i % 2) d[15:11] = ex_of(i);
        ok = cal_ok(i, d);
        acc(1'b1, 1'b0, cmds[i], d);
        if (ok) cm[i] = d;
        stat(ok ? 8'h00 : 8'h40);
        acc(1'b0, 1'b0, cmds[i], 16'h0000);
        check(rd, cm[i], "cal word");
      end
    end
    chk_cal();
    acc(1'b1, 1'b0, 8'hd0, {8'h00, nm, 2'b10});
    check({15'h0000, write_protect}, 16'h0001, "wpe on");
    acc(1'b1, 1'b0, 8'hd2, {`PMSCR_EXP_VOUT, 11'h055});
    stat(8'h40);
    chk_cal();
    // temperature status latching and clearing
    rwait(1);
    overtemp_fault_flag_evt = 1'b1;
    rwait(1);
    overtemp_fault_flag_evt = 1'b0;
    tstat(8'h80);
    rwait(1);
    overtemp_warning_flag_evt = 1'b1;
    rwait(1);
    overtemp_warning_flag_evt = 1'b0;
    tstat(8'hc0);
    acc(1'b1, 1'b0, 8'h7d, 16'h0080);
    tstat(8'h40);
    acc(1'b1, 1'b0, 8'h03, 16'h0000);
    tstat(8'h00);
    // bad command, bad packet check, writes to read-only places
    acc(1'b0, 1'b0, 8'h55, 16'h0000);
    stat(8'h80);
    acc(1'b0, 1'b1, 8'h88, 16'h0000);
    stat(8'h20);
    acc(1'b1, 1'b0, 8'h88, 16'h1234);
    stat(8'h40);
    acc(1'b0, 1'b0, 8'h03, 16'h0000);
    stat(8'h80);
    // telemetry and revision readback
    for (int j = 0; j < 3; j++) begin
      rwait(1);
      telem = {$random(seed), $random(seed)};
      fw_rev = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'($random(seed));
      rwait(2);
      for (int t = 0; t < 4; t++) begin
        acc(1'b0, 1'b0, tcmd[t], 16'h0000);
        check(rd, telem[63-16*t -: 16], "telemetry");
      end
      acc(1'b1, 1'b0, 8'hdb, 16'h0012);
      stat(8'h40);
      acc(1'b0, 1'b0, 8'hdb, 16'h0000);
      check(rd, {8'h00, fw_rev}, "fw revision");
    end
    // every pin code, with and without the load-share strap
    cfg = 8'h00;
    for (int ls = 0; ls < 2; ls++) begin
      rwait(1);
      load_share_opt = ls[0];
      rwait(4);
      for (int code = 0; code < 16; code++) begin
        d = {8'h00, 4'($random(seed)), code[3:0]};
        ok = code <= 2 && (ls == 0 || code == 0);
        acc(1'b1, 1'b0, 8'he0, d);
        if (ok) cfg = {3'b000, d[4:0]};
        stat(ok ? 8'h00 : 8'h40);
        acc(1'b0, 1'b0, 8'he0, 16'h0000);
        check(rd, {8'h00, cfg}, "pin config");
        check({12'h000, pin_func}, {12'h000, cfg[3:0]}, "pin func");
      end
    end
    // alert address answering follows the config bit and the alert line
    rwait(1);
    smbalert = 1'b1;
    acc(1'b1, 1'b0, 8'he0, 16'h0000);
    rwait(5);
    check({15'h0000, ara_only}, 16'h0000, "ara off");
    acc(1'b1, 1'b0, 8'he0, 16'h0010);
    rwait(5);
    check({15'h0000, ara_only}, 16'h0001, "ara on");
    smbalert = 1'b0;
    rwait(5);
    check({15'h0000, ara_only}, 16'h0000, "ara idle");
    check({15'h0000, link_busy}, 16'h0000, "busy idle");
    close_out();
  end
endmodule // power_module_status_cal_regs_tb
